// [aso_pkg.sv]
package aso_pkg;
  // ----------------------------------------
  // widths and depths
  // ----------------------------------------
  localparam int RES_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  // ----------------------------------------
  // shared pin positions on the data bus
  // ----------------------------------------
  localparam int PIN_CLKSRC = 4;
  localparam int PIN_FRAMEPOL = 5;
  localparam int PIN_CLKINV = 6;
  localparam int PIN_RDMODE_CHAIN = 7;
  localparam int PIN_SDO = 8;
  localparam int PIN_SCLK = 9;
  localparam int PIN_FRAME = 10;
  localparam int PIN_RDERR = 11;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_QUARTER_NS = 20;
  localparam int SCLK_QUARTER_CYC =
    (SCLK_QUARTER_NS / CLK_PERIOD_NS) < 1 ? 1 : (SCLK_QUARTER_NS / CLK_PERIOD_NS);
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] RESULT_RST = 16'h0000;
  // strobes rest high so the read path stays off through reset
  localparam logic [3:0] SYNC_CTRL_RST = 4'h3;
  // ----------------------------------------
  // engine states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MASTER = 2'b01,
    ST_SLAVE = 2'b10
  } aso_state_t;
endpackage : aso_pkg

// [aso_stream_if.sv]
interface aso_stream_if #(
  parameter int WIDTH = 16
);
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;
  modport fifo (input wr_valid, output wr_ready, input wr_data, output rd_valid, input rd_ready, output rd_data);
  modport user (output wr_valid, input wr_ready, output wr_data, input rd_valid, output rd_ready, input rd_data);
endinterface : aso_stream_if

// [aso_fifo.sv]
module aso_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  aso_stream_if.fifo s
);
  import aso_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  wire push = s.wr_valid & s.wr_ready;
  wire pop = s.rd_valid & s.rd_ready;
  wire empty = (wp_q == rp_q);
  wire full = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  assign s.wr_ready = ~full;
  assign s.rd_valid = ~empty;
  assign s.rd_data = mem_q[rp_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= s.wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk) disable iff (sys_rst)
    full |=> ($past(wp_q) == wp_q) || $past(pop)) else $error("fifo written while full");
endmodule : aso_fifo

// [aso_top.sv]
// Functional notes
// [RULE_01] parallel mode drives bits 7..11 on pins
// [RULE_02] bit-7 pin: chain input or read mode
// [RULE_03] external clock: chain input follows after 16
// [RULE_04] internal clock, mode high: read during conversion
// [RULE_05] internal clock, mode low: read after conversion
// [RULE_06] serial result goes out MSB first
// [RULE_07] coding select pin chooses result coding
// [RULE_08] high binary, low inverts MSB
// [RULE_09] internal clock: data stable across both edges
// [RULE_10] external, invert low: change on rising
// [RULE_11] external, invert high: change on falling
// [RULE_12] clock pin direction from clock source select
// [RULE_13] low drives internal clock, high follows host
// [RULE_14] polarity low: frame marker high while valid
// [RULE_15] polarity high: frame marker low while valid
// [RULE_16] external clock: bit-11 pin flags incomplete read
// [RULE_17] unfinished slave read at completion: drop, pulse
// [RULE_18] host holds select and read low
// [RULE_19] sixteen bits per frame, then idle
// [RULE_20] external clock keeps frame marker inactive; code puts the inactive level on bus_out but leaves the pin undriven
module aso_top #(
  parameter int RES_W = aso_pkg::RES_W,
  parameter int FIFO_DEPTH = aso_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic port_mode_select,
  input wire logic output_coding_select,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic core_busy,
  input wire logic core_result_valid,
  input wire logic [aso_pkg::RES_W-1:0] core_result,
  output logic core_result_ready,
  input wire logic [aso_pkg::RES_W-1:0] bus_in,
  output logic [aso_pkg::RES_W-1:0] bus_out,
  output logic [aso_pkg::RES_W-1:0] bus_oe
);
  import aso_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [RES_W+3:0] meta_q;
  logic [RES_W+3:0] sync_q;
  logic sclk_prev_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= {SYNC_CTRL_RST, {RES_W{1'b0}}};
      sync_q <= {SYNC_CTRL_RST, {RES_W{1'b0}}};
      sclk_prev_q <= 1'b0;
    end else begin
      meta_q <= {output_coding_select, port_mode_select, rd_n, cs_n, bus_in};
      sync_q <= meta_q;
      sclk_prev_q <= sync_q[PIN_SCLK];
    end
  end

  wire [RES_W-1:0] pin_s = sync_q[RES_W-1:0];
  wire cs_n_s = sync_q[RES_W];
  wire rd_n_s = sync_q[RES_W+1];
  wire serial_s = sync_q[RES_W+2];
  wire coding_s = sync_q[RES_W+3];
  wire rd_en = ~cs_n_s & ~rd_n_s; // RULE_18
  wire ext_clk = pin_s[PIN_CLKSRC]; // RULE_13
  wire frame_pol = pin_s[PIN_FRAMEPOL];
  wire clk_inv = pin_s[PIN_CLKINV];
  wire rd_mode = pin_s[PIN_RDMODE_CHAIN] & ~ext_clk; // RULE_02
  wire chain_in = pin_s[PIN_RDMODE_CHAIN] & ext_clk; // RULE_02
  wire sclk_rise = sync_q[PIN_SCLK] & ~sclk_prev_q;
  wire sclk_fall = ~sync_q[PIN_SCLK] & sclk_prev_q;
  // the host's clock only counts while chip select is low
  wire slave_edge = ~cs_n_s & (clk_inv ? sclk_fall : sclk_rise); // RULE_10 RULE_11

  // inverting the msb turns offset binary into twos complement
  function automatic logic [RES_W-1:0] apply_coding(input logic [RES_W-1:0] w, input logic straight);
    apply_coding = {w[RES_W-1] ^ ~straight, w[RES_W-2:0]};
  endfunction : apply_coding

  // ----------------------------------------
  // result buffer
  // ----------------------------------------
  aso_stream_if #(.WIDTH(RES_W)) buf_if ();
  aso_fifo #(.WIDTH(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .s(buf_if)
  );
  assign buf_if.wr_valid = core_result_valid;
  assign buf_if.wr_data = core_result;
  assign core_result_ready = buf_if.wr_ready;
  wire new_result = buf_if.wr_valid & buf_if.wr_ready;

  // ----------------------------------------
  // serial engine
  // ----------------------------------------
  aso_state_t state_q;
  aso_state_t state_d;
  logic [RES_W-1:0] shreg_q;
  logic [RES_W-1:0] par_q;
  logic [4:0] bit_cnt_q;
  logic [1:0] phase_q;
  logic [7:0] qdiv_q;
  logic err_q;

  wire idle = (state_q == ST_IDLE);
  // mode high may start while busy; mode low waits for the core to finish
  wire mode_ok = rd_mode | ~core_busy; // RULE_04 RULE_05
  wire start_master = idle & serial_s & ~ext_clk & rd_en & buf_if.rd_valid & mode_ok;
  wire start_slave = idle & serial_s & ext_clk & rd_en & buf_if.rd_valid;
  wire par_load = ~serial_s & buf_if.rd_valid;
  assign buf_if.rd_ready = start_master | start_slave | par_load;
  wire [RES_W-1:0] head_coded = apply_coding(buf_if.rd_data, coding_s); // RULE_07 RULE_08
  wire quarter_tick = (qdiv_q == 8'(SCLK_QUARTER_CYC - 1));
  wire master_shift = (state_q == ST_MASTER) & quarter_tick & (phase_q == 2'h3);
  wire slave_done = (bit_cnt_q == FRAME_BITS);
  // a fresh result mid-read overrides the old one rather than stalling the core
  wire slave_abort = (state_q == ST_SLAVE) & ~slave_done & new_result; // RULE_17
  wire master_last = master_shift & (bit_cnt_q == FRAME_BITS - 5'h01);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_master) state_d = ST_MASTER;
        else if (start_slave) state_d = ST_SLAVE;
      end
      ST_MASTER: begin
        if (master_last) state_d = ST_IDLE; // RULE_19
      end
      ST_SLAVE: begin
        if (slave_abort) state_d = ST_IDLE;
        else if (slave_done & cs_n_s) state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) state_q <= ST_IDLE;
    else state_q <= state_d;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      qdiv_q <= 8'h00;
      phase_q <= 2'h0;
    end else if (state_q != ST_MASTER) begin
      qdiv_q <= 8'h00;
      phase_q <= 2'h0;
    end else if (quarter_tick) begin
      qdiv_q <= 8'h00;
      phase_q <= phase_q + 2'h1;
    end else begin
      qdiv_q <= qdiv_q + 8'h01;
    end
  end

  // data moves at phase 0, clock edges sit at phases 1 and 3
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shreg_q <= RESULT_RST;
      bit_cnt_q <= 5'h00;
    end else if (start_master | start_slave) begin
      shreg_q <= head_coded; // RULE_06
      bit_cnt_q <= 5'h00;
    end else if (master_shift) begin
      shreg_q <= {shreg_q[RES_W-2:0], 1'b0}; // RULE_06 RULE_09
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end else if ((state_q == ST_SLAVE) & slave_edge) begin
      // chain bits fall out after the sixteenth edge
      shreg_q <= {shreg_q[RES_W-2:0], chain_in}; // RULE_03
      if (!slave_done) bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) par_q <= RESULT_RST;
    else if (par_load) par_q <= head_coded;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) err_q <= 1'b0;
    else err_q <= slave_abort; // RULE_17
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  wire master_on = (state_q == ST_MASTER);
  wire sclk_int = (phase_q[0] ^ phase_q[1]) ^ clk_inv;
  wire frame_act = master_on & ~ext_clk;
  wire frame_lvl = frame_act ^ frame_pol; // RULE_14 RULE_15 RULE_20
  wire [RES_W-1:0] ser_word = {4'h0, err_q, frame_lvl, sclk_int, shreg_q[RES_W-1], 8'h00};
  wire [RES_W-1:0] in_pins = (RES_W'(1) << PIN_CLKSRC) | (RES_W'(1) << PIN_FRAMEPOL) |
    (RES_W'(1) << PIN_CLKINV) | (RES_W'(1) << PIN_RDMODE_CHAIN);
  wire [RES_W-1:0] ser_oe_base = ({RES_W{rd_en}} & ~in_pins & ~(RES_W'(1) << PIN_SCLK) &
    ~(RES_W'(1) << PIN_FRAME) & ~(RES_W'(1) << PIN_RDERR));
  // a one-bit name keeps the cast from widening the inversion
  wire int_clk = ~ext_clk;
  wire [RES_W-1:0] ser_oe = ser_oe_base | (RES_W'(int_clk) << PIN_SCLK) | // RULE_12
    (RES_W'(int_clk) << PIN_FRAME) | (RES_W'(ext_clk) << PIN_RDERR); // RULE_16
  assign bus_out = serial_s ? ser_word : par_q; // RULE_01
  assign bus_oe = serial_s ? ser_oe : {RES_W{rd_en}}; // RULE_01

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_PAR_BITS: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    (!serial_s && rd_en) |-> (bus_out[11:7] == par_q[11:7]) && (&bus_oe[11:7]))
    else $error("parallel bits 7..11 not driven");
  AST_CHAIN_SHIFT: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
    (state_q == ST_SLAVE && slave_edge && !slave_abort) |=> shreg_q[0] == $past(chain_in))
    else $error("chain input not shifted in");
  AST_MSB_FIRST: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
    (start_master || start_slave) |=> bus_out[PIN_SDO] == $past(head_coded[RES_W-1]))
    else $error("first serial bit is not the msb");
  AST_CODING: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
    par_load |=> par_q[RES_W-1] == ($past(buf_if.rd_data[RES_W-1]) ^ ~$past(coding_s)))
    else $error("msb coding wrong");
  AST_WAIT_DONE: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    (idle && serial_s && !ext_clk && !rd_mode && core_busy) |=> state_q != ST_MASTER)
    else $error("read started during conversion");
  AST_SCLK_DIR: assert property (@(posedge clk) disable iff (sys_rst) // RULE_12
    serial_s |-> bus_oe[PIN_SCLK] == !ext_clk) else $error("clock pin direction wrong");
  AST_FRAME_LEVEL: assert property (@(posedge clk) disable iff (sys_rst) // RULE_14
    (serial_s && master_on && !ext_clk) |-> bus_out[PIN_FRAME] == !frame_pol)
    else $error("frame marker not active during frame");
  AST_FRAME_SLAVE: assert property (@(posedge clk) disable iff (sys_rst) // RULE_20
    (serial_s && ext_clk) |-> bus_out[PIN_FRAME] == frame_pol) else $error("frame marker active in slave");
  AST_ERR_PULSE: assert property (@(posedge clk) disable iff (sys_rst) // RULE_17
    slave_abort |=> err_q && state_q == ST_IDLE ##1 !err_q) else $error("incomplete read not flagged");
  AST_DATA_STABLE: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
    (master_on && $past(master_on) && phase_q != 2'h0) |-> $stable(shreg_q))
    else $error("serial data moved near a clock edge");
  AST_FRAME_LEN: assert property (@(posedge clk) disable iff (sys_rst) // RULE_19
    start_master |-> ##128 master_on ##1 idle) else $error("master frame length wrong");
  AST_SLAVE_EDGE: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
    (state_q == ST_SLAVE && $past(state_q) == ST_SLAVE && shreg_q != $past(shreg_q))
    |-> $past(slave_edge)) else $error("slave data moved without its edge");
  CVR_MASTER_FRAME: cover property (@(posedge clk) disable iff (sys_rst) master_last);
  CVR_SLAVE_DONE: cover property (@(posedge clk) disable iff (sys_rst) state_q == ST_SLAVE && slave_done);
  CVR_ABORT: cover property (@(posedge clk) disable iff (sys_rst) slave_abort);
  CVR_FIFO_FULL: cover property (@(posedge clk) disable iff (sys_rst) !core_result_ready);
endmodule : aso_top

// [aso_host_model.sv]
module aso_host_model (
  output logic sclk,
  input wire logic dev_sclk,
  input wire logic sdo,
  input wire logic ext,
  input wire logic inv
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // capture
  // ----------------------------------------
  logic [31:0] sh_a;
  logic [31:0] sh_b;
  int cnt;
  // sampling edge is the one opposite the update edge
  wire smp = ext ? (sclk ^ ~inv) : (dev_sclk ^ inv);
  initial begin
    sclk = 1'b1;
    clr();
  end
  always @(posedge smp) begin
    sh_a = {sh_a[30:0], sdo};
    cnt++;
  end
  // internal clock: a second copy on the other edge
  always @(negedge smp) begin
    if (!ext) begin
      sh_b = {sh_b[30:0], sdo};
    end
  end
  task clr();
    sh_a = 32'h0;
    sh_b = 32'h0;
    cnt = 0;
  endtask : clr
  // rest level chosen so that the first edge of a frame samples the msb
  task idle();
    sclk = ~inv;
  endtask : idle
  // clock only runs inside frames; half sets a prompt or slow pace
  task frame(input int n, input int half);
    repeat (n) begin
      #(half) sclk = ~sclk;
      #(half) sclk = ~sclk;
    end
  endtask : frame
endmodule : aso_host_model

// [tb_top.sv]
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import aso_pkg::*;
  logic clk, sys_rst, pms, ocs, cs_n, rd_n, busy, cvalid, csrc, fpol, cinv, pin7;
  logic [15:0] cres;
  wire cready, hsclk;
  wire [15:0] bus_out, bus_oe, bus_w, host_pins;
  int err_total, tests_run, cyc, hi_cnt;
  // undriven host-side bits show the inverse of the pin so stale values never match
  assign host_pins = {~bus_out[15:10], hsclk, ~bus_out[8], pin7, cinv, fpol, csrc, ~bus_out[3:0]};
  assign bus_w = (bus_oe & bus_out) | (~bus_oe & host_pins);
  aso_top #(.RES_W(16), .FIFO_DEPTH(32)) DUT (.clk(clk), .sys_rst(sys_rst), .port_mode_select(pms),
    .output_coding_select(ocs), .cs_n(cs_n), .rd_n(rd_n), .core_busy(busy), .core_result_valid(cvalid),
    .core_result(cres), .core_result_ready(cready), .bus_in(bus_w), .bus_out(bus_out), .bus_oe(bus_oe));
  aso_host_model host (.sclk(hsclk), .dev_sclk(bus_w[9]), .sdo(bus_w[8]), .ext(csrc), .inv(cinv));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 15000) begin
      err_total++;
      wrap_up();
    end
  end
  // mid-cycle sampling keeps the flag count clear of the edge that launches it
  always @(negedge clk) begin
    if (bus_out[11] === 1'b1) hi_cnt++;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  function logic [15:0] cod(input logic [15:0] w, input logic ob);
    cod = ob ? w : (w ^ 16'h8000);
  endfunction : cod
  function logic [15:0] wv(input int i);
    wv = 16'(i) * 16'h9E37 + 16'h1234;
  endfunction : wv
  // leaves valid high so that fills run back to back
  task push(input logic [15:0] w);
    int i;
    i = 0;
    cres = w;
    cvalid = 1'b1;
    while (cready !== 1'b1 && i < 100) begin
      step(1);
      i++;
    end
    if (i == 100) err_total++;
    step(1);
  endtask : push
  task mframe(input int k);
    int i;
    fpol = k[0];
    cinv = k[1];
    ocs = k[2];
    step(6);
    host.clr();
    `CHK(bus_w[10], fpol)
    if (k[3]) pin7 = 1'b1;
    else busy = 1'b0;
    i = 0;
    while (bus_w[10] !== ~fpol && i < 50) begin
      step(1);
      i++;
    end
    if (i == 50) err_total++;
    pin7 = 1'b0;
    busy = 1'b1;
    `CHK(bus_oe[10:9], 2'b11)
    i = 0;
    while (bus_w[10] !== fpol && i < 300) begin
      step(1);
      i++;
    end
    if (i == 300) err_total++;
    step(2);
    `CHK(host.sh_a[15:0], cod(wv(k), k[2]))
    `CHK(host.sh_b[15:0], cod(wv(k), k[2]))
    `CHK(host.cnt, 16)
  endtask : mframe
  task sframe(input logic [15:0] w, input logic inv, input int half, input logic ch, input logic ob, input int n);
    cs_n = 1'b1;
    cinv = inv;
    pin7 = ch;
    ocs = ob;
    host.idle();
    step(4);
    host.clr();
    cs_n = 1'b0;
    step(4);
    host.frame(n, half);
    step(4);
    if (n == 20) begin
      `CHK(host.sh_a[19:0], {cod(w, ob), {4{ch}}})
      `CHK(bus_oe[11:9], 3'b100)
      `CHK(bus_out[10], fpol)
    end
  endtask : sframe
  task wrap_up();
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    {clk, pms, busy, cvalid, csrc, fpol, cinv, pin7} = 8'h00;
    {sys_rst, ocs, cs_n, rd_n} = 4'hF;
    cres = 16'h0000;
    {err_total, tests_run, cyc, hi_cnt} = {4{32'h0}};
    step(12);
    sys_rst = 1'b0;
    step(3);
    cs_n = 1'b0;
    rd_n = 1'b0;
    for (int k = 0; k < 2; k++) begin
      ocs = k[0];
      step(3);
      push(wv(40 + k));
      cvalid = 1'b0;
      step(8);
      `CHK(bus_out, cod(wv(40 + k), k[0]))
      `CHK(bus_oe, 16'hFFFF)
    end
    // fill while reads are disabled, then overrun by one
    {cs_n, rd_n, pms} = 3'b111;
    step(4);
    for (int k = 0; k < 32; k++) push(wv(k));
    cres = 16'hDEAD;
    step(5);
    `CHK(cready, 1'b0)
    cvalid = 1'b0;
    busy = 1'b1;
    {cs_n, rd_n} = 2'b00;
    for (int k = 0; k < 32; k++) mframe(k);
    csrc = 1'b1;
    fpol = 1'b1;
    push(16'h6A0C);
    cvalid = 1'b0;
    sframe(16'h6A0C, 1'b0, 40, 1'b1, 1'b1, 20);
    push(16'h93F1);
    cvalid = 1'b0;
    sframe(16'h93F1, 1'b1, 120, 1'b0, 1'b0, 20);
    // slave read cut short by the next result
    push(16'h0F5A);
    cvalid = 1'b0;
    sframe(16'h0F5A, 1'b0, 40, 1'b0, 1'b1, 5);
    hi_cnt = 0;
    push(16'hC3E7);
    cvalid = 1'b0;
    step(6);
    `CHK(hi_cnt, 1)
    sframe(16'hC3E7, 1'b0, 40, 1'b1, 1'b1, 20);
    wrap_up();
  end
endmodule : tb_top
